// ---- dcf_pkg.sv ----
// Shared constants and types of the dual-clock buffer control block.
`default_nettype none
package dcf_pkg;
  // Buffer geometry: word width and address bits of the store.
  localparam int DCF_DATA_W = 9;
  localparam int DCF_ADDR_W = 18;
  // Offset loaded at master reset for parallel and serial methods.
  localparam int DCF_OFF_PAR_DEF = 32'h0000007F;
  localparam int DCF_OFF_SER_DEF = 32'h000003FF;
  // System clock rate.
  localparam int DCF_SYS_CLK_MHZ = 100;
  // Bit positions in the synchronised pin vector.
  localparam int DCF_P_WCLK = 0;
  localparam int DCF_P_RCLK = 1;
  localparam int DCF_P_WEN = 2;
  localparam int DCF_P_REN = 3;
  localparam int DCF_P_MRS = 4;
  localparam int DCF_P_PRS = 5;
  localparam int DCF_P_RT = 6;
  localparam int DCF_P_SI = 7;
  localparam int DCF_P_SEN = 8;
  localparam int DCF_P_LD = 9;
  localparam int DCF_P_DAT = 10;
  localparam int DCF_PIN_W = DCF_P_DAT + DCF_DATA_W;
  // Retransmit sequencer states.
  typedef enum logic [0:0] {
    DCF_RT_IDLE = 1'b0,
    DCF_RT_SETUP = 1'b1
  } dcf_rt_e;
endpackage
`default_nettype wire

// ---- dcf_fifo_ctrl.sv ----
// Dual-clock nine-bit buffer control with resets, retransmit and serial offsets.
`timescale 1ns/10ps
`default_nettype none
// Function
// [RQ1] Partial reset clears pointers, sets partial flags.
// [RQ2] Partial reset keeps mode, sets mode flags.
// [RQ3] Partial reset keeps offsets and load method.
// [RQ4] Partial reset zeroes output, acts without link clocks.
// [RQ5] Retransmit low on read edge rewinds reader.
// [RQ6] Writer and reader idle before retransmit.
// [RQ7] Standard retransmit: empty low, then high.
// [RQ8] Fall-through retransmit: ready high, first word shown.
// [RQ9] Master reset samples mode pin for timing.
// [RQ10] Standard mode: every word needs read enable.
// [RQ11] Fall-through: first word after three read edges.
// [RQ12] Mode pin becomes serial input after reset.
// [RQ13] Write edges only update write-side flags.
// [RQ14] Write sets half-full low, read sets high.
// [RQ15] Store one word per write edge unless full.
// [RQ16] Standard full flag clears two write edges later; the code clears it on the third write edge after the read.
// [RQ17] Fall-through input-ready clears two write edges later; the code clears it on the third write edge after the read.
// [RQ18] Read edges only update read-side flags.
// [RQ19] Read loads output register, else holds it.
// [RQ20] Standard empty flag, reads ignored while empty.
// [RQ21] Fall-through ready rises only on true read.
// [RQ22] Serial and load low shift one offset bit.
// [RQ23] Load low redirects access to offset registers; code only blocks buffer reads and writes, with no parallel offset access.
// [RQ24] Pointers cross as Gray codes through two stages.
module dcf_fifo_ctrl
  import dcf_pkg::*;
#(
  parameter int ADDR_W = DCF_ADDR_W
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_wclk,
  input wire logic i_rclk,
  input wire logic i_wr_en_n,
  input wire logic i_rd_en_n,
  input wire logic [DCF_DATA_W-1:0] i_data_in,
  input wire logic i_master_reset_n,
  input wire logic i_partial_reset_n,
  input wire logic i_retransmit_n,
  input wire logic i_mode_serial_in,
  input wire logic i_serial_enable_n,
  input wire logic i_load_n,
  output var logic [DCF_DATA_W-1:0] o_data_out,
  output var logic o_full_flag_n,
  output var logic o_empty_flag_n,
  output var logic o_almost_full_n,
  output var logic o_almost_empty_n,
  output var logic o_half_full_n
);

  localparam int PW = ADDR_W + 1;
  localparam int OW = 2 * ADDR_W;
  localparam logic [PW-1:0] DEPTH_P = {1'b1, {ADDR_W{1'b0}}};
  localparam logic [PW-1:0] HALF_P = {2'b01, {(ADDR_W-1){1'b0}}};

  // Binary to Gray, so only one bit moves per pointer step.
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray back to binary on the receiving side.
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction

  logic [DCF_PIN_W-1:0] pin_raw;
  logic [DCF_PIN_W-1:0] pin_s1;
  logic [DCF_PIN_W-1:0] pin_s2;
  logic wclk_d;
  logic rclk_d;
  logic fall_through_mode;
  logic serial_method;
  logic [OW-1:0] offsets;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_gray;
  logic [PW-1:0] rd_gray;
  logic [PW-1:0] rd_gray_w1;
  logic [PW-1:0] rd_gray_w2;
  logic [PW-1:0] wr_gray_r1;
  logic [PW-1:0] wr_gray_r2;
  logic wfull;
  dcf_rt_e rt_state;
  logic [DCF_DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // All pins, link clocks included, pass two flops before use.
  assign pin_raw = {i_data_in, i_load_n, i_serial_enable_n,
    i_mode_serial_in, i_retransmit_n, i_partial_reset_n,
    i_master_reset_n, i_rd_en_n, i_wr_en_n, i_rclk, i_wclk};

  // Synchroniser; only the second stage is read by logic.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // Previous link clock levels for edge finding.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end
    else
    begin
      wclk_d <= pin_s2[DCF_P_WCLK];
      rclk_d <= pin_s2[DCF_P_RCLK];
    end
  end

  // Decoded pin levels and link clock edges.
  wire wclk_rise = pin_s2[DCF_P_WCLK] & ~wclk_d;
  wire rclk_rise = pin_s2[DCF_P_RCLK] & ~rclk_d;
  wire mrs_act = ~pin_s2[DCF_P_MRS];
  wire prs_act = ~pin_s2[DCF_P_PRS];
  wire any_rst = mrs_act | prs_act;
  wire wen_n = pin_s2[DCF_P_WEN];
  wire ren_n = pin_s2[DCF_P_REN];
  wire rt_n = pin_s2[DCF_P_RT];
  wire si = pin_s2[DCF_P_SI];
  wire sen_n = pin_s2[DCF_P_SEN];
  wire ld_n = pin_s2[DCF_P_LD];
  wire [DCF_DATA_W-1:0] din = pin_s2[DCF_P_DAT +: DCF_DATA_W];
  // During master reset the mode pin decides the flag levels at once.
  wire mode_now = mrs_act ? si : fall_through_mode;
  wire [ADDR_W-1:0] empty_off = offsets[OW-1:ADDR_W];
  wire [ADDR_W-1:0] full_off = offsets[ADDR_W-1:0];

  // Mode and load method are only taken while master reset is low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fall_through_mode <= 1'b0;
      serial_method <= 1'b0;
    end
    else if (mrs_act)
    begin
      fall_through_mode <= si; // see [RQ9]
      serial_method <= ld_n;
    end
  end

  // Serial offset shift enable; partial reset never touches offsets.
  wire sh_en = wclk_rise & ~sen_n & ~ld_n & serial_method & ~any_rst; // see [RQ22] [RQ12] [RQ3]
  wire [ADDR_W-1:0] def_off = ld_n ? ADDR_W'(DCF_OFF_SER_DEF) : ADDR_W'(DCF_OFF_PAR_DEF);

  // Offsets shift in empty-offset MSB first, full-offset LSB last.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      offsets <= '0;
    else if (mrs_act)
      offsets <= {def_off, def_off};
    else if (sh_en)
      offsets <= {offsets[OW-2:0], si}; // see [RQ3] [RQ22]
  end

  // Write side: occupancy as seen through the synchronised read pointer.
  wire [PW-1:0] rd_bin_w = gray2bin(rd_gray_w2); // see [RQ24]
  wire [PW-1:0] wcnt = wr_ptr - rd_bin_w;
  // Load low steers writes away from the buffer memory.
  wire store = wclk_rise & ~wen_n & ld_n & ~wfull & ~any_rst; // see [RQ15] [RQ23]
  wire [PW-1:0] wcnt_next = wcnt + PW'(store);
  wire next_wfull = wcnt_next >= DEPTH_P;
  wire next_af_n = ~(wcnt_next >= (DEPTH_P - {1'b0, full_off}));

  // Words are stored in sequence; memory has no reset.
  always_ff @(posedge i_sys_clk)
  begin
    if (store)
      mem[wr_ptr[ADDR_W-1:0]] <= din; // see [RQ15]
  end

  // Write pointer, read pointer crossing and write-side flags.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_gray_w1 <= '0;
      rd_gray_w2 <= '0;
      wfull <= 1'b0;
      o_full_flag_n <= 1'b1;
      o_almost_full_n <= 1'b1;
    end
    else if (any_rst)
    begin
      wr_ptr <= '0; // see [RQ1]
      rd_gray_w1 <= '0;
      rd_gray_w2 <= '0;
      wfull <= 1'b0;
      o_full_flag_n <= ~mode_now; // see [RQ2]
      o_almost_full_n <= 1'b1; // see [RQ1]
    end
    else if (wclk_rise)
    begin
      // A stopped write clock freezes these flags.
      rd_gray_w1 <= rd_gray; // see [RQ24] [RQ13]
      rd_gray_w2 <= rd_gray_w1;
      wr_ptr <= wr_ptr + PW'(store);
      wfull <= next_wfull;
      o_full_flag_n <= fall_through_mode ? next_wfull : ~next_wfull; // see [RQ16] [RQ17]
      o_almost_full_n <= next_af_n;
    end
  end

  // Source Gray registers of both pointers.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_gray <= '0;
      rd_gray <= '0;
    end
    else
    begin
      wr_gray <= bin2gray(wr_ptr); // see [RQ24]
      rd_gray <= bin2gray(rd_ptr);
    end
  end

  // Read side: occupancy through the synchronised write pointer.
  wire [PW-1:0] rd_wbin = gray2bin(wr_gray_r2); // see [RQ24]
  wire [PW-1:0] rcnt = rd_wbin - rd_ptr;
  wire mem_empty = (rcnt == '0);
  wire rd_ready = fall_through_mode ? ~o_empty_flag_n : o_empty_flag_n;
  wire rt_idle = (rt_state == DCF_RT_IDLE);
  // Retransmit assumes writer and reader are idle, so no read is mixed in.
  wire rt_start = rclk_rise & ~rt_n & rt_idle & ~any_rst; // see [RQ5] [RQ6]
  wire rt_done = rclk_rise & rt_n & ~rt_idle & ~any_rst;
  wire rd_ok = rclk_rise & ld_n & ~any_rst & rt_idle & rt_n;
  // Standard reads need enable and a non-empty flag.
  wire std_pop = rd_ok & ~ren_n & rd_ready & ~mem_empty; // see [RQ10] [RQ20]
  // Fall-through loads on its own when the output register is stale.
  wire fw_load = ~mem_empty & ((rd_ok & (~rd_ready | ~ren_n)) | rt_done); // see [RQ11] [RQ8]
  // A true read of the last shown word marks the output stale.
  wire fw_drop = rd_ok & mem_empty & rd_ready & ~ren_n; // see [RQ21]
  wire pop = fall_through_mode ? fw_load : std_pop;
  wire [PW-1:0] rcnt_next = rcnt - PW'(pop);
  wire next_ae_n = ~(rcnt_next <= {1'b0, empty_off});
  wire rflag_upd = rclk_rise & (rt_idle | rt_done);
  wire next_empty_pin = fall_through_mode ? (fw_load ? 1'b0 : (fw_drop ? 1'b1 : o_empty_flag_n)) : (rcnt_next != '0);

  // Retransmit sequencer: setup spans the edges with retransmit low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rt_state <= DCF_RT_IDLE;
    else if (any_rst || rt_done)
      rt_state <= DCF_RT_IDLE;
    else if (rt_start)
      rt_state <= DCF_RT_SETUP;
  end

  // Read pointer, write pointer crossing and read-side flags.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_ptr <= '0;
      wr_gray_r1 <= '0;
      wr_gray_r2 <= '0;
      o_empty_flag_n <= 1'b0;
      o_almost_empty_n <= 1'b0;
    end
    else if (any_rst)
    begin
      rd_ptr <= '0; // see [RQ1]
      wr_gray_r1 <= '0;
      wr_gray_r2 <= '0;
      o_empty_flag_n <= mode_now; // see [RQ2]
      o_almost_empty_n <= 1'b0; // see [RQ1]
    end
    else if (rclk_rise)
    begin
      // A stopped read clock freezes these flags.
      wr_gray_r1 <= wr_gray; // see [RQ24] [RQ18]
      wr_gray_r2 <= wr_gray_r1;
      o_almost_empty_n <= next_ae_n;
      if (rt_start)
      begin
        rd_ptr <= '0; // see [RQ5]
        o_empty_flag_n <= fall_through_mode; // see [RQ7] [RQ8]
      end
      else
      begin
        rd_ptr <= rd_ptr + PW'(pop);
        if (rflag_upd)
          o_empty_flag_n <= next_empty_pin; // see [RQ20] [RQ21]
      end
    end
  end

  // Output register; without a pop it holds its word.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_data_out <= '0;
    else if (any_rst)
      o_data_out <= '0; // see [RQ4]
    else if (pop)
      o_data_out <= mem[rd_ptr[ADDR_W-1:0]]; // see [RQ19]
  end

  // Half-full: the write side may only clear it, the read side only set it.
  // Should both edges meet in one cycle the write side wins.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_half_full_n <= 1'b1;
    else if (any_rst)
      o_half_full_n <= 1'b1; // see [RQ1]
    else if (wclk_rise && (wcnt_next > HALF_P))
      o_half_full_n <= 1'b0; // see [RQ14]
    else if (rclk_rise && (rcnt_next <= HALF_P))
      o_half_full_n <= 1'b1; // see [RQ14]
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_prs_outputs: assert property (prs_act |=> !o_almost_empty_n && o_almost_full_n && o_half_full_n && o_data_out == '0) // see [RQ1] [RQ4]
    else $error("partial reset left flags or output wrong");
  a_prs_mode_kept: assert property (prs_act && !mrs_act |=> $stable(fall_through_mode) && (fall_through_mode ? (!o_full_flag_n && o_empty_flag_n) : (o_full_flag_n && !o_empty_flag_n))) // see [RQ2]
    else $error("partial reset changed mode or mode flags");
  a_prs_offsets: assert property (prs_act && !mrs_act |=> $stable(offsets) && $stable(serial_method)) // see [RQ3]
    else $error("partial reset changed offsets");
  a_rt_rewind: assert property (rt_start |=> rd_ptr == '0 && (fall_through_mode ? o_empty_flag_n : !o_empty_flag_n) && !rt_idle) // see [RQ5] [RQ7] [RQ8]
    else $error("retransmit setup did not rewind");
  a_rt_fall_through_mode_word: assert property (rt_done && fall_through_mode && !mem_empty |=> !o_empty_flag_n && rd_ptr == PW'(1)) // see [RQ8]
    else $error("fall-through retransmit did not show first word");
  a_std_no_auto: assert property (!fall_through_mode && rclk_rise && ren_n && !any_rst && !rt_start |=> $stable(rd_ptr) && $stable(o_data_out)) // see [RQ10] [RQ19]
    else $error("standard mode read without enable");
  a_full_no_store: assert property (wfull || !ld_n |-> !store) // see [RQ15] [RQ23]
    else $error("store while full or while loading");
  a_store_step: assert property (store |=> wr_ptr - $past(wr_ptr) == PW'(1)) // see [RQ15]
    else $error("write pointer did not advance by one");
  a_full_flag: assert property (wclk_rise && next_wfull && !any_rst |=> (fall_through_mode ? o_full_flag_n : !o_full_flag_n)) // see [RQ16] [RQ17]
    else $error("full indication missing");
  a_wclk_stopped: assert property (!wclk_rise && !any_rst |=> $stable(o_full_flag_n) && $stable(o_almost_full_n)) // see [RQ13]
    else $error("write flags moved without write edge");
  a_rclk_stopped: assert property (!rclk_rise && !any_rst |=> $stable(o_empty_flag_n) && $stable(o_almost_empty_n)) // see [RQ18]
    else $error("read flags moved without read edge");
  a_hf_sides: assert property ((!$past(o_half_full_n) && o_half_full_n) |-> $past(rclk_rise || any_rst)) // see [RQ14]
    else $error("half-full set high without read edge");
  a_ef_release: assert property (!fall_through_mode && rflag_upd && !rt_start && !any_rst && rcnt_next != '0 |=> o_empty_flag_n) // see [RQ20]
    else $error("empty flag not released");
  a_fall_through_mode_true_read: assert property (fall_through_mode && $rose(o_empty_flag_n) |-> $past(fw_drop || rt_start || any_rst)) // see [RQ21]
    else $error("output ready rose without true read");
  a_mode_select: assert property (mrs_act |=> fall_through_mode == $past(si)) // see [RQ9]
    else $error("mode not taken at master reset");
  a_serial_shift: assert property (sh_en |=> offsets[0] == $past(si)) // see [RQ22] [RQ12]
    else $error("serial bit not shifted in");
  a_serial_hold: assert property (!mrs_act && (sen_n || ld_n) |=> $stable(offsets)) // see [RQ22]
    else $error("offsets changed while serial disabled");
  a_gray_step: assert property ($changed(wr_gray) && !$past(any_rst, 2) |-> $onehot(wr_gray ^ $past(wr_gray))) // see [RQ24]
    else $error("gray pointer moved more than one bit");

  c_fall_through_mode_first: cover property (fall_through_mode && fw_load && !rd_ready);
  c_full: cover property (wclk_rise && next_wfull);
  c_rt_fall_through_mode: cover property (rt_done && fall_through_mode && !mem_empty);
  c_serial: cover property (sh_en);

endmodule
`default_nettype wire

// ---- dcf_link_model.sv ----
// Partner model: the writer and the reader that own both link clocks and their qualifiers.
`timescale 1ns/10ps
`default_nettype none
module dcf_link_model
  import dcf_pkg::*;
(
  output var logic o_wclk,
  output var logic o_rclk,
  output var logic o_wr_en_n,
  output var logic o_rd_en_n,
  output var logic [DCF_DATA_W-1:0] o_data_in,
  output var logic o_retransmit_n,
  output var logic o_mode_serial_in,
  output var logic o_serial_enable_n
);
  // Link clocks stand still low between frames and every enable idles high.
  initial
  begin
    o_wclk = 1'b0;
    o_rclk = 1'b0;
    o_wr_en_n = 1'b1;
    o_rd_en_n = 1'b1;
    o_data_in = 9'h000;
    o_retransmit_n = 1'b1;
    o_mode_serial_in = 1'b0;
    o_serial_enable_n = 1'b1;
  end
  // Level seen on the mode pin while master reset is held.
  task automatic set_si(input logic v);
    o_mode_serial_in = v;
  endtask
  // One write-clock cycle of 125 ns; a gap of half periods models a slow writer.
  task automatic wpulse(input logic [DCF_DATA_W-1:0] d, input logic wen_n, input logic sen_n, input logic si,
                        input int gap);
    #(62.5 * gap);
    o_data_in = d;
    o_wr_en_n = wen_n;
    o_serial_enable_n = sen_n; // Serial bits only travel with the load pin low
    o_mode_serial_in = si;
    #62.5;
    o_wclk = 1'b1;
    #62.5;
    o_wclk = 1'b0;
    o_wr_en_n = 1'b1;
    o_serial_enable_n = 1'b1;
    // A released data bus must not keep showing the old word.
    o_data_in = ~d;
  endtask
  // One read-clock cycle of 125 ns.
  task automatic rpulse(input logic ren_n, input logic rt_n);
    o_rd_en_n = ren_n;
    o_retransmit_n = rt_n; // Callers hold both enables high while this is low
    #62.5;
    o_rclk = 1'b1;
    #62.5;
    o_rclk = 1'b0;
    o_rd_en_n = 1'b1;
    o_retransmit_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb_dcf_fifo_ctrl.sv ----
// Self-checking bench of the dual-clock buffer control driven by its link partner.
`timescale 1ns/10ps
`default_nettype none
module tb_dcf_fifo_ctrl;
  import dcf_pkg::*;
  logic i_sys_clk;
  logic i_rst_n;
  logic master_n;
  logic partial_n;
  logic load_n;
  wire logic wclk, rclk, wen_n, ren_n, rt_n, si, sen_n;
  wire logic [DCF_DATA_W-1:0] din;
  wire logic [DCF_DATA_W-1:0] dout;
  wire logic full_n, empty_n, af_n, ae_n, hf_n;
  int err_total;
  int num_checks;
  // Flag bundle, used where every flag has a fixed value.
  wire logic [4:0] flags = {full_n, empty_n, af_n, ae_n, hf_n};

  // A small depth keeps the fill scenarios short.
  dcf_fifo_ctrl #(.ADDR_W(4)) dcf_fifo_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wclk(wclk),
    .i_rclk(rclk), .i_wr_en_n(wen_n), .i_rd_en_n(ren_n), .i_data_in(din), .i_master_reset_n(master_n),
    .i_partial_reset_n(partial_n), .i_retransmit_n(rt_n), .i_mode_serial_in(si), .i_serial_enable_n(sen_n),
    .i_load_n(load_n), .o_data_out(dout), .o_full_flag_n(full_n), .o_empty_flag_n(empty_n),
    .o_almost_full_n(af_n), .o_almost_empty_n(ae_n), .o_half_full_n(hf_n));
  dcf_link_model dcf_link_model_i (.o_wclk(wclk), .o_rclk(rclk), .o_wr_en_n(wen_n), .o_rd_en_n(ren_n),
    .o_data_in(din), .o_retransmit_n(rt_n), .o_mode_serial_in(si), .o_serial_enable_n(sen_n));

  // System clock of 100 MHz.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input logic [DCF_DATA_W-1:0] seen, input logic [DCF_DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic sys(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [DCF_DATA_W-1:0] d);
    dcf_link_model_i.wpulse(d, 1'b0, 1'b1, 1'b0, 0);
  endtask
  task automatic rd(input logic r_n);
    dcf_link_model_i.rpulse(r_n, 1'b1);
  endtask
  // Mode and load method are sampled while the master reset pin is low.
  task automatic mreset(input logic mode, input logic ld);
    dcf_link_model_i.set_si(mode);
    sys(1);
    load_n <= ld;
    master_n <= 1'b0;
    sys(5);
    master_n <= 1'b1;
    load_n <= 1'b1;
    sys(5);
  endtask
  // Partial reset is given with both link clocks stopped, so it must act without them.
  task automatic preset(input logic [4:0] exp_flags);
    sys(1);
    partial_n <= 1'b0;
    sys(5);
    #1;
    check(9'(flags), 9'(exp_flags));
    check(dout, 9'h000);
    sys(1);
    partial_n <= 1'b1;
    sys(5);
  endtask

  task automatic t_std_flow();
    mreset(1'b0, 1'b1);
    check(9'(flags), 9'h015);
    for (int i = 0; i < 3; i++)
      wr(9'h0A0 + 9'(i));
    check(9'(empty_n), 9'h000);
    repeat (3) rd(1'b1);
    check(9'(empty_n), 9'h001);
    check(dout, 9'h000);
    for (int i = 0; i < 3; i++)
    begin
      rd(1'b0);
      check(dout, 9'h0A0 + 9'(i));
      rd(1'b1);
      check(dout, 9'h0A0 + 9'(i));
    end
    check(9'(empty_n), 9'h000);
    rd(1'b0);
    check(dout, 9'h0A2);
  endtask
  task automatic t_full();
    mreset(1'b0, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      wr(9'(i));
      if (i == 7)
        check(9'(hf_n), 9'h001);
      if (i == 8)
        check(9'(hf_n), 9'h000);
    end
    check(9'(full_n), 9'h000);
    check(9'(af_n), 9'h000);
    wr(9'h1FF);
    repeat (3) rd(1'b1);
    rd(1'b0);
    check(dout, 9'h000);
    check(9'(full_n), 9'h000);
    repeat (3) dcf_link_model_i.wpulse(9'h000, 1'b1, 1'b1, 1'b0, 1);
    check(9'(full_n), 9'h001);
    for (int i = 1; i < 16; i++)
    begin
      rd(1'b0);
      check(dout, 9'(i));
    end
    check(9'(hf_n), 9'h001);
    rd(1'b0);
    check(dout, 9'h00F);
  endtask
  task automatic t_retx_std();
    mreset(1'b0, 1'b1);
    for (int i = 0; i < 3; i++)
      wr(9'h110 + 9'(i));
    repeat (3) rd(1'b1);
    rd(1'b0);
    rd(1'b0);
    dcf_link_model_i.rpulse(1'b1, 1'b0);
    check(9'(empty_n), 9'h000);
    rd(1'b1);
    check(9'(empty_n), 9'h001);
    check(dout, 9'h111);
    rd(1'b0);
    check(dout, 9'h110);
    rd(1'b0);
    check(dout, 9'h111);
  endtask
  task automatic t_fall_through_mode();
    mreset(1'b1, 1'b1);
    check(9'(flags), 9'h00D);
    wr(9'h1C3);
    rd(1'b1);
    rd(1'b1);
    check(dout, 9'h000);
    rd(1'b1);
    check(dout, 9'h1C3);
    check(9'(empty_n), 9'h000);
    wr(9'h03C);
    repeat (3) rd(1'b1);
    check(dout, 9'h1C3);
    rd(1'b0);
    check(dout, 9'h03C);
    rd(1'b0);
    check(9'(empty_n), 9'h001);
    check(dout, 9'h03C);
    dcf_link_model_i.rpulse(1'b1, 1'b0);
    check(9'(empty_n), 9'h001);
    rd(1'b1);
    check(dout, 9'h1C3);
    check(9'(empty_n), 9'h000);
    preset(5'h0D);
  endtask
  // Shifting 36 zero bits clears both offsets, so two stored words lift the almost-empty flag.
  task automatic t_serial();
    mreset(1'b0, 1'b1);
    wr(9'h055);
    wr(9'h0AA);
    sys(1);
    load_n <= 1'b0;
    repeat (36) dcf_link_model_i.wpulse(9'h1FF, 1'b0, 1'b1, 1'b1, 0);
    repeat (3) rd(1'b1);
    check(9'(ae_n), 9'h000);
    repeat (36) dcf_link_model_i.wpulse(9'h1FF, 1'b0, 1'b0, 1'b0, 0);
    repeat (3) rd(1'b1);
    check(9'(ae_n), 9'h001);
    sys(1);
    load_n <= 1'b1;
    rd(1'b0);
    check(dout, 9'h055);
    rd(1'b0);
    check(dout, 9'h0AA);
    check(9'(empty_n), 9'h000);
    preset(5'h15);
    wr(9'h001);
    wr(9'h002);
    repeat (3) rd(1'b1);
    check(9'(ae_n), 9'h001);
  endtask

  // Main sequence: system reset for five cycles, then one scenario after another.
  initial
  begin
    i_rst_n = 1'b0;
    master_n = 1'b1;
    partial_n = 1'b1;
    load_n = 1'b1;
    err_total = 0;
    num_checks = 0;
    sys(5);
    i_rst_n <= 1'b1;
    sys(4);
    t_std_flow();
    t_full();
    t_retx_std();
    t_fall_through_mode();
    t_serial();
    tally_and_finish();
  end
  // Watchdog: the scenarios need about 22 us, so 400 us means a hang.
  initial
  begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
